// file: rtl/relay_spi_device.sv
// Behaviour
// - reply comes only in the next frame
// - bad clock count gives error reply
// - reset or soft reset gives special reply
// - prefix 11 write is syntax error
// - prefix 00 read is syntax error
// - unused register address is syntax error
// - bit15 0, bit0 1 returns diagnosis
// - write frame stores byte except at id address, diagnosis next
// - read frame returns echoed address, byte
// - drive output only while selected
// - sample input on serial clock fall
// - success is 16, 24 or 32 clocks
// - act on frame at select rise
// - first reply error flag plus identity
// - one shift register, in and out
`timescale 1ns/100ps
module relay_spi_device
    import relay_spi_pkg::*;
#(
    // arbitrary identification value
    parameter logic [7:0] ID_VALUE = 8'h5a
) (
    // clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_b,
    // serial link
    relay_spi_if.device                link,
    // device status and control
    input  wire relay_spi_pkg::frame_t i_diag_status,
    input  wire logic                  i_soft_reset,
    // register write report
    output logic                       o_wr_valid,
    output logic [5:0]                 o_wr_addr,
    output logic [7:0]                 o_wr_data,
    // frame result
    output logic                       o_transfer_error_flag,
    output logic                       o_syntax_err
);
    import relay_spi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic cs_level;
    logic cs_rise;
    logic cs_fall;
    logic sclk_fall;
    logic mosi_level;

    // select idles high, so it resets high to avoid a false rise
    sync_edge #(.RESET_VAL(1'b1)) u_sync_cs (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_async   (link.chip_select_low),
        .o_level   (cs_level),
        .o_rise    (cs_rise),
        .o_fall    (cs_fall)
    );

    sync_edge #(.RESET_VAL(1'b0)) u_sync_sclk (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_async   (link.sclk),
        .o_level   (),
        .o_rise    (),
        .o_fall    (sclk_fall)
    );

    // same latency as the clock, so data stays aligned to its edge
    sync_edge #(.RESET_VAL(1'b0)) u_sync_mosi (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_async   (link.mosi),
        .o_level   (mosi_level),
        .o_rise    (),
        .o_fall    ()
    );

    ////////////////////////////////////////////////////////////////////////////////
    // state
    dev_state_t           state;
    dev_state_t           next_state;
    frame_t               shift;
    logic [CNT_W-1:0]     clk_cnt;
    logic                 transfer_error_flag;
    reply_kind_t          kind;
    logic [ADDR_W-1:0]    reply_addr;
    logic [7:0]           reply_byte;
    logic [7:0]           mem [64];

    ////////////////////////////////////////////////////////////////////////////////
    // frame decode
    logic [1:0]        prefix;
    logic [ADDR_W-1:0] addr_idx;
    logic [7:0]        data_byte;
    logic              count_ok;
    logic              is_diag;
    logic              is_read;
    logic              is_write;
    logic              addr_used;
    logic              syntax_err;
    logic              do_write;
    logic [7:0]        read_byte;
    logic              frame_end;

    assign prefix    = shift[15:14];
    assign addr_idx  = shift[13:8];
    assign data_byte = shift[7:0];

    assign count_ok  = (clk_cnt >= CNT_W'(FRAME_BITS))
                     && (clk_cnt <= CNT_W'(FRAME_BITS + MAX_EXTRA * BYTE_BITS))
                     && (clk_cnt[2:0] == 3'h0);

    assign is_diag   = !shift[15] && shift[0];
    assign is_read   = (prefix == PREFIX_READ) && (shift[1:0] == READ_TAIL);
    assign is_write  = (prefix == PREFIX_WRITE);
    assign addr_used = USED_MAP[addr_idx];
    assign syntax_err = !is_diag && !((is_read || is_write) && addr_used);

    assign frame_end = cs_rise && (state == DEV_FRAME);
    assign do_write  = frame_end && count_ok && !syntax_err && is_write && !is_diag
                     && (addr_idx != ID_IDX);
    assign read_byte = (addr_idx == ID_IDX) ? ID_VALUE : mem[addr_idx];

    ////////////////////////////////////////////////////////////////////////////////
    // reply word chosen at select fall
    frame_t diag_word;
    frame_t reply_word;

    assign diag_word = (i_diag_status & DIAG_KEEP)
                     | (frame_t'(transfer_error_flag) << XFER_FLAG_BIT);

    always_comb
    begin
        case (kind)
            KIND_DIAG:   reply_word = diag_word;
            KIND_READ:   reply_word = {PREFIX_WRITE, reply_addr, reply_byte};
            KIND_SYNTAX: reply_word = SYNTAX_REPLY;
            KIND_ID:     reply_word = {diag_word[15:8], ID_VALUE};
            default:     reply_word = diag_word;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // select state machine
    always_comb
    begin
        case (state)
            DEV_IDLE:  next_state = cs_fall ? DEV_FRAME : DEV_IDLE;
            DEV_FRAME: next_state = cs_rise ? DEV_IDLE : DEV_FRAME;
            default:   next_state = DEV_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            state <= DEV_IDLE;
        else
            state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shift register and clock count
    // one register in and out
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            shift   <= 16'h0000;
            clk_cnt <= 6'h00;
        end
        else if (cs_fall)
        begin
            shift   <= reply_word;
            clk_cnt <= 6'h00;
        end
        else if (sclk_fall && state == DEV_FRAME)
        begin
            shift   <= {shift[14:0], mosi_level};
            // saturates so long bursts still count as bad
            clk_cnt <= (&clk_cnt) ? clk_cnt : clk_cnt + 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // frame result and next reply kind
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            transfer_error_flag <= 1'b1;
            kind       <= KIND_ID;
            reply_addr <= 6'h00;
            reply_byte <= 8'h00;
        end
        else if (i_soft_reset)
        begin
            transfer_error_flag <= 1'b1;
            kind <= KIND_ID;
        end
        else if (frame_end)
        begin
            transfer_error_flag <= !count_ok;
            reply_addr <= addr_idx;
            reply_byte <= read_byte;
            if (!count_ok)
                kind <= KIND_DIAG;
            else if (syntax_err)
                kind <= KIND_SYNTAX;
            else if (is_read && !is_diag)
                kind <= KIND_READ;
            else
                kind <= KIND_DIAG;
        end
        else if (cs_fall && kind == KIND_ID)
        begin
            kind <= KIND_DIAG;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register bank, cleared by either reset
    genvar g;
    generate
        for (g = 0; g < 64; g++)
        begin : g_mem
            always_ff @(posedge i_ref_clk or negedge i_rst_b)
            begin
                if (!i_rst_b)
                    mem[g] <= 8'h00;
                else if (i_soft_reset)
                    mem[g] <= 8'h00;
                else if (do_write && addr_idx == ADDR_W'(g))
                    mem[g] <= data_byte;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // user side reports
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_wr_valid   <= 1'b0;
            o_wr_addr    <= 6'h00;
            o_wr_data    <= 8'h00;
            o_syntax_err <= 1'b0;
        end
        else
        begin
            o_wr_valid   <= do_write;
            o_wr_addr    <= do_write ? addr_idx : o_wr_addr;
            o_wr_data    <= do_write ? data_byte : o_wr_data;
            o_syntax_err <= frame_end && count_ok && syntax_err;
        end
    end

    assign link.miso_oe       = (state == DEV_FRAME);
    assign link.miso_out      = shift[15];
    assign o_transfer_error_flag = transfer_error_flag;
endmodule : relay_spi_device

// file: pkg/relay_spi_pkg.sv
package relay_spi_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // clock and link timing
    localparam int CLK_MHZ        = 200;
    localparam int SCLK_PERIOD_NS = 200;
    localparam int CS_LEAD_NS     = 200;
    localparam int CS_LAG_NS      = 200;
    localparam int CS_GAP_NS      = 250;
    // least times round up to whole cycles
    localparam int HALF_CYC       = (SCLK_PERIOD_NS * CLK_MHZ + 1999) / 2000;
    localparam int LEAD_CYC       = (CS_LEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int LAG_CYC        = (CS_LAG_NS * CLK_MHZ + 999) / 1000;
    localparam int GAP_CYC        = (CS_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int TIMER_W        = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // frame layout
    localparam int FRAME_BITS = 16;
    localparam int BYTE_BITS  = 8;
    localparam int MAX_EXTRA  = 2;
    localparam int CNT_W      = 6;
    localparam int ADDR_W     = 6;
    localparam int XFER_FLAG_BIT = 10;
    localparam logic [1:0]  PREFIX_WRITE = 2'h2;
    localparam logic [1:0]  PREFIX_READ  = 2'h1;
    localparam logic [1:0]  READ_TAIL    = 2'h2;
    localparam logic [15:0] DIAG_RESET   = 16'h7800;
    localparam logic [15:0] DIAG_KEEP    = 16'h7dff;
    localparam logic [15:0] SYNTAX_REPLY = 16'hffff;
    localparam logic [ADDR_W-1:0] ID_IDX = 6'h00;
    localparam logic [63:0] USED_MAP     = 64'h0000_0000_0000_ffff;

    ////////////////////////////////////////////////////////////////////////////////
    // controller registers, byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_TX       = 8'h04;
    localparam logic [7:0] OFS_RX       = 8'h08;
    localparam logic [7:0] OFS_STAT     = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_CNT_LSB   = 8;
    localparam logic [CNT_W-1:0] CNT_RESET = 6'h10;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef logic [15:0] frame_t;
    typedef logic [31:0] word_t;
    typedef logic [7:0]  apb_addr_t;
    typedef enum logic [1:0] {KIND_DIAG, KIND_READ, KIND_SYNTAX, KIND_ID} reply_kind_t;
    typedef enum logic {DEV_IDLE = 1'b0, DEV_FRAME = 1'b1} dev_state_t;
    // lag to gap is the only two-bit step; both middle codes decode as deselected
    typedef enum logic [2:0] {
        H_IDLE = 3'b000, H_LEAD = 3'b001, H_HIGH = 3'b011,
        H_LOW  = 3'b010, H_LAG  = 3'b111, H_GAP  = 3'b100
    } host_state_t;

endpackage : relay_spi_pkg

// file: pkg/relay_spi_if.sv
`timescale 1ns/100ps
interface relay_spi_if;
    logic chip_select_low;
    logic sclk;
    logic mosi;
    logic miso_out;
    logic miso_oe;
    wire  miso;

    // released line is seen high by the master
    assign miso = miso_oe ? miso_out : 1'b1;

    modport device (input chip_select_low, input sclk, input mosi,
                    output miso_out, output miso_oe);
    modport host   (output chip_select_low, output sclk, output mosi, input miso);
endinterface : relay_spi_if

// file: rtl/sync_edge.sv
`timescale 1ns/100ps
module sync_edge #(
    parameter logic RESET_VAL = 1'b0
) (
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst_b,
    // asynchronous level in
    input  wire logic i_async,
    // synchronised level and its edges
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);
    logic meta;
    logic stable;
    logic prev;

    // meta is read by stable alone
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta   <= RESET_VAL;
            stable <= RESET_VAL;
            prev   <= RESET_VAL;
        end
        else
        begin
            meta   <= i_async;
            stable <= meta;
            prev   <= stable;
        end
    end

    // edges from the two stable stages
    assign o_level = stable;
    assign o_rise  = stable & ~prev;
    assign o_fall  = ~stable & prev;
endmodule : sync_edge

// file: rtl/relay_spi_host.sv
`timescale 1ns/100ps
module relay_spi_host
    import relay_spi_pkg::*;
(
    // clock and reset
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_rst_b,
    // apb slave
    input  wire logic                     i_psel,
    input  wire logic                     i_penable,
    input  wire logic                     i_pwrite,
    input  wire relay_spi_pkg::apb_addr_t i_paddr,
    input  wire relay_spi_pkg::word_t     i_pwdata,
    output relay_spi_pkg::word_t          o_prdata,
    output logic                          o_pready,
    output logic                          o_pslverr,
    // interrupt
    output logic                          o_irq,
    // serial link
    relay_spi_if.host                     link
);
    import relay_spi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // miso passes two flops before use
    logic miso_level;

    sync_edge #(.RESET_VAL(1'b1)) u_sync_miso (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_async   (link.miso),
        .o_level   (miso_level),
        .o_rise    (),
        .o_fall    ()
    );

    ////////////////////////////////////////////////////////////////////////////////
    // registers and state
    host_state_t          state;
    host_state_t          next_state;
    logic [TIMER_W-1:0]   timer;
    logic [CNT_W-1:0]     bit_cnt;
    logic [CNT_W-1:0]     bit_total;
    word_t                tx;
    word_t                rx;
    logic                 irq_stat;
    logic                 irq_mask;

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode; answers in the access cycle, no wait states
    logic wr_en;
    logic rd_en;
    logic busy;
    logic start;
    logic done;
    logic t_zero;

    assign wr_en     = i_psel && i_penable && i_pwrite;
    assign rd_en     = i_psel && !i_pwrite;
    assign busy      = (state != H_IDLE);
    // a start while busy is dropped
    assign start     = wr_en && i_paddr == OFS_CTRL && i_pwdata[CTRL_START_BIT] && !busy;
    assign t_zero    = (timer == 8'h00);
    assign done      = (state == H_LAG) && t_zero;
    assign o_pready  = 1'b1;
    assign o_pslverr = 1'b0;
    assign o_irq     = irq_stat & irq_mask;

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_prdata <= 32'h0000_0000;
        else if (rd_en)
        begin
            case (i_paddr)
                OFS_CTRL:     o_prdata <= word_t'(bit_total) << CTRL_CNT_LSB;
                OFS_TX:       o_prdata <= tx;
                OFS_RX:       o_prdata <= rx;
                OFS_STAT:     o_prdata <= word_t'(busy);
                OFS_IRQ_STAT: o_prdata <= word_t'(irq_stat);
                OFS_IRQ_MASK: o_prdata <= word_t'(irq_mask);
                default:      o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    // event set wins over write-one clear
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            irq_stat  <= 1'b0;
            irq_mask  <= 1'b0;
            bit_total <= CNT_RESET;
        end
        else
        begin
            irq_stat <= done | (irq_stat & ~(wr_en && i_paddr == OFS_IRQ_STAT && i_pwdata[0]));
            if (wr_en && i_paddr == OFS_IRQ_MASK)
                irq_mask <= i_pwdata[0];
            if (start)
                bit_total <= i_pwdata[CTRL_CNT_LSB +: CNT_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // frame sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            H_IDLE:  if (start) next_state = H_LEAD;
            H_LEAD:  if (t_zero) next_state = H_HIGH;
            H_HIGH:  if (t_zero) next_state = (bit_cnt + 6'h01 == bit_total) ? H_LAG : H_LOW;
            H_LOW:   if (t_zero) next_state = H_HIGH;
            H_LAG:   if (t_zero) next_state = H_GAP;
            H_GAP:   if (t_zero) next_state = H_IDLE;
            default: next_state = H_IDLE;
        endcase
    end

    // each phase reloads its own wait
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state   <= H_IDLE;
            timer   <= 8'h00;
            bit_cnt <= 6'h00;
        end
        else
        begin
            state <= next_state;
            if (next_state != state)
            begin
                case (next_state)
                    H_LEAD:  timer <= TIMER_W'(LEAD_CYC - 1);
                    H_LAG:   timer <= TIMER_W'(LAG_CYC - 1);
                    H_GAP:   timer <= TIMER_W'(GAP_CYC - 1);
                    default: timer <= TIMER_W'(HALF_CYC - 1);
                endcase
            end
            else if (!t_zero)
                timer <= timer - 8'h01;
            if (start)
                bit_cnt <= 6'h00;
            else if (state == H_HIGH && t_zero)
                bit_cnt <= bit_cnt + 6'h01;
        end
    end

    // data changes at clock rise, held through the device's sampling fall
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            tx <= 32'h0000_0000;
            rx <= 32'h0000_0000;
        end
        else if (wr_en && i_paddr == OFS_TX && !busy)
            tx <= i_pwdata;
        else if (state == H_LOW && t_zero)
            tx <= {tx[30:0], 1'b0};
        else if (state == H_HIGH && t_zero)
            rx <= {rx[30:0], miso_level};
    end

    assign link.chip_select_low = !(state == H_LEAD || state == H_HIGH
                                 || state == H_LOW || state == H_LAG);
    assign link.sclk            = (state == H_HIGH);
    assign link.mosi            = tx[31];
endmodule : relay_spi_host

// file: tb/relay_spi_frame_asserts.sv
`timescale 1ns/100ps
module relay_spi_frame_asserts (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // link lines
    input wire logic chip_select_low,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso_out,
    input wire logic miso_oe
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    ////////////////////////////////////////////////////////////////////////////////
    // quiet stretches on the wire
    sequence s_sclk_quiet;
        !sclk [*8];
    endsequence
    sequence s_select_held;
        !chip_select_low [*8];
    endsequence

    ////////////////////////////////////////////////////////////////////////////////
    // output drive follows select, released soon after
    property p_oe_after_select;
        $rose(miso_oe) |-> !chip_select_low && $past(!chip_select_low, 2);
    endproperty
    property p_oe_release;
        $rose(chip_select_low) |-> ##[1:5] !miso_oe;
    endproperty
    property p_oe_idle;
        chip_select_low [*6] |-> !miso_oe;
    endproperty
    // output bit moves only in the low phase after a fall
    property p_shift_on_fall;
        miso_oe && $past(miso_oe) && $changed(miso_out) |-> $past(!sclk) && $past(!sclk, 2);
    endproperty
    // input held steady around the sampling edge
    property p_mosi_hold;
        $fell(sclk) |-> mosi == $past(mosi, 2) ##1 $stable(mosi);
    endproperty
    property p_lead;
        $fell(chip_select_low) |-> s_sclk_quiet;
    endproperty
    property p_lag;
        $fell(sclk) |-> s_select_held;
    endproperty
    property p_gap;
        $rose(chip_select_low) |-> chip_select_low [*8];
    endproperty
    property p_sclk_idle;
        chip_select_low |-> !sclk;
    endproperty

    a_oe_after_select: assert property (p_oe_after_select)
        else $error("output driven without select");
    a_oe_release: assert property (p_oe_release)
        else $error("output not released after select rise");
    a_oe_idle: assert property (p_oe_idle)
        else $error("output driven while deselected");
    a_shift_on_fall: assert property (p_shift_on_fall)
        else $error("output bit moved outside clock low phase");
    a_mosi_hold: assert property (p_mosi_hold)
        else $error("input moved around sampling edge");
    a_lead: assert property (p_lead)
        else $error("clock too soon after select");
    a_lag: assert property (p_lag)
        else $error("select rose too soon after last bit");
    a_gap: assert property (p_gap)
        else $error("frames too close");
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("clock high outside frame");
endmodule : relay_spi_frame_asserts

// file: tb/test_relay_driver_spi_frame_protocol.sv
`timescale 1ns/100ps
module test_relay_driver_spi_frame_protocol;
    import relay_spi_pkg::*;
    // arbitrary identification value
    localparam logic [7:0] ID_ARB = 8'h3c;
    localparam frame_t     DIAG   = 16'h5866;
    localparam frame_t     FIRST  = {DIAG[15:8] | 8'h04, ID_ARB};
    logic       i_ref_clk, i_rst_b, i_psel, i_penable, i_pwrite, i_soft_reset;
    logic       o_pready, o_pslverr, o_irq, o_wr_valid, o_transfer_error_flag, o_syntax_err;
    apb_addr_t  i_paddr;
    word_t      i_pwdata, o_prdata, rx;
    logic [5:0] o_wr_addr;
    logic [7:0] o_wr_data;
    int         n_errors, compares, n_syn = 0, n_wr = 0, bad[3] = '{17, 8, 12};

    relay_spi_if link ();
    relay_spi_host relay_spi_host_i (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .o_irq(o_irq), .link(link));
    relay_spi_device #(.ID_VALUE(ID_ARB)) relay_spi_device_i (.i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b), .link(link), .i_diag_status(DIAG), .i_soft_reset(i_soft_reset),
        .o_wr_valid(o_wr_valid), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
        .o_transfer_error_flag(o_transfer_error_flag), .o_syntax_err(o_syntax_err));
    relay_spi_frame_asserts relay_spi_frame_asserts_i (.i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b), .chip_select_low(link.chip_select_low), .sclk(link.sclk),
        .mosi(link.mosi), .miso_out(link.miso_out), .miso_oe(link.miso_oe));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and pulse tallies
    initial
    begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk)
        if (o_syntax_err === 1'b1) n_syn <= n_syn + 1;
    always @(posedge i_ref_clk)
        if (o_wr_valid === 1'b1) n_wr <= n_wr + 1;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one apb transfer, waits for pready; only the watchdog ends a hang
    task automatic apb(input logic wr, input apb_addr_t a, input word_t d, output word_t q);
        @(posedge i_ref_clk);
        i_psel   <= 1'b1;
        i_pwrite <= wr;
        i_paddr  <= a;
        i_pwdata <= d;
        @(posedge i_ref_clk);
        i_penable <= 1'b1;
        do
            @(posedge i_ref_clk);
        while (o_pready !== 1'b1);
        q = o_prdata;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    // start a frame of cnt clocks, wait until idle, fetch received bits
    task automatic xfer(input int cnt, input word_t tx, output word_t q);
        apb(1'b1, OFS_TX, tx, q);
        apb(1'b1, OFS_CTRL, word_t'(cnt << CTRL_CNT_LSB) | 32'h1, q);
        do
            apb(1'b0, OFS_STAT, 32'h0, q);
        while (q[0] !== 1'b0);
        apb(1'b0, OFS_RX, 32'h0, q);
    endtask : xfer

    task automatic frame16(input frame_t f, input frame_t exp, input string what);
        xfer(16, {f, 16'h0}, rx);
        check(what, {16'h0, rx[15:0]}, {16'h0, exp});
    endtask : frame16

    task automatic give_verdict;
        $display("compares %0d, errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog, well beyond some seventeen frames
    initial
    begin
        #400000;
        n_errors++;
        give_verdict();
    end

    initial
    begin
        {i_rst_b, i_psel, i_penable, i_pwrite, i_soft_reset} = 5'h00;
        i_paddr  = 8'h00;
        i_pwdata = 32'h0;
        n_errors = 0;
        compares = 0;
        repeat (4) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        // reset reply, then write, read and diagnosis
        frame16(16'h0001, FIRST, "first reply");
        check("error flag", 32'(o_transfer_error_flag), 32'h0);
        frame16(16'h89a5, DIAG, "diag after id");
        check("write address", 32'(o_wr_addr), 32'h09);
        check("write data", 32'(o_wr_data), 32'ha5);
        frame16(16'h4902, DIAG, "write reply");
        frame16(16'h0001, 16'h89a5, "read reply");
        xfer(24, 32'hc3000100, rx);
        check("long frame", rx & 32'hffffff, {8'h0, DIAG, 8'hc3});
        $display("test frames done");
        // bad clock counts
        foreach (bad[k])
        begin
            xfer(bad[k], 32'h00010000, rx);
            check("flag set", 32'(o_transfer_error_flag), 32'h1);
            frame16(16'h0001, DIAG | 16'h0400, "error reply");
        end
        $display("test counts done");
        // syntax errors
        frame16(16'hc000, DIAG, "before syntax");
        frame16(16'h0000, SYNTAX_REPLY, "prefix 11");
        frame16(16'h9400, SYNTAX_REPLY, "prefix 00");
        frame16(16'h0001, SYNTAX_REPLY, "unused address");
        check("syntax pulses", n_syn, 3);
        check("write pulses", n_wr, 1);
        $display("test syntax done");
        // soft reset
        @(posedge i_ref_clk);
        i_soft_reset <= 1'b1;
        @(posedge i_ref_clk);
        i_soft_reset <= 1'b0;
        frame16(16'h4902, FIRST, "soft reset reply");
        frame16(16'h0001, 16'h8900, "cleared register");
        $display("test soft reset done");
        // controller registers and interrupt
        apb(1'b0, OFS_CTRL, 32'h0, rx);
        check("count field", rx, 32'h1000);
        apb(1'b0, 8'h20, 32'h0, rx);
        check("unmapped", rx, 32'h0);
        check("slave error", 32'(o_pslverr), 32'h0);
        apb(1'b1, OFS_IRQ_MASK, 32'h1, rx);
        @(negedge i_ref_clk);
        check("irq raised", 32'(o_irq), 32'h1);
        apb(1'b1, OFS_IRQ_STAT, 32'h1, rx);
        @(negedge i_ref_clk);
        check("irq cleared", 32'(o_irq), 32'h0);
        $display("test registers done");
        give_verdict();
    end
endmodule : test_relay_driver_spi_frame_protocol
